// >>> rtl/atc_pkg.sv
// package of the acquisition trigger controller: states, sources, sizes.
// assumes a single clock domain and synchronous inputs.
package atc_pkg;
    // ----------------------------------------------------------------
    // trigger states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE      = 5'h01,
        ST_ARM       = 5'h02,
        ST_ARMED     = 5'h04,
        ST_TRIGGERED = 5'h08,
        ST_DONE      = 5'h10
    } atc_state_type;

    // ----------------------------------------------------------------
    // trigger source codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SRC_SOFT = 3'h0;
    localparam logic [2:0] SRC_COAX = 3'h1;
    localparam logic [2:0] SRC_JACK = 3'h2;
    localparam logic [2:0] SRC_X = 3'h3;
    localparam logic [2:0] SRC_Y = 3'h4;
    localparam logic [2:0] SRC_Z = 3'h5;

    // ----------------------------------------------------------------
    // sizes and reset values
    // ----------------------------------------------------------------
    localparam int OFFSET_W = 64;
    localparam int FIELD_W = 16;
    localparam int COUNT_W = 16;
    localparam int MAX_POINTS = 8;
    localparam int IDX_W = 3;
    localparam int TO_W = 32;
    // one second at 40 MHz
    localparam int CLK_HZ = 40000000;
    localparam logic [TO_W-1:0] CYCLES_PER_S = TO_W'(CLK_HZ);
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
endpackage : atc_pkg

// >>> rtl/atc_trigger_ctrl.sv
// trigger state machine, source selection, point offsets and connector
// direction of the field-probe acquisition interface.
// assumes a command decoder that pulses the command inputs for one cycle
// and a sample strobe plus signed axis samples from the acquisition path.
`timescale 1ns/100ps

// Notes on behaviour
// - point trigger count is kept; equals configured points once DONE, or 1 when 0 points are configured
// - each later point records 64-bit sample offset from first point
// - offset list holds one entry fewer than configured points
// - offset list invalid unless DONE and more than one point
// - five states IDLE ARM ARMED TRIGGERED DONE, state reported
// - done wait ends at once on DONE, IDLE or zero timeout
// - arm command moves to ARMED from any state
// - armed wait ends at once on ARMED or zero timeout
// - armed status is 1 only in ARMED
// - clear command moves to IDLE from any state
// - force command enters TRIGGERED whatever source is selected
// - done status is 1 only in DONE
// - detected trigger events are counted and readable
// - six sources; software source triggers only by force
// - first external is coax trigger, second is jack trigger
// - axis source compares selected axis field against threshold
// - axis trigger fires when field crosses the threshold
// - direction 0 rising, 1 falling moves ARMED to TRIGGERED
// - coax output enable drives output and blocks coax input
// - DONE reached only after configured number of valid triggers
// - each point captures configured sample count into buffer
// - first captured sample lies at signed offset from trigger
// - output polarity 0 gives rising edge, 1 falling edge
module atc_trigger_ctrl
    import atc_pkg::*;
#(
    parameter int POINTS_MAX = MAX_POINTS
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic cmd_arm_i,
    input wire logic cmd_clear_i,
    input wire logic cmd_force_i,
    input wire logic [2:0] source_i,
    input wire logic falling_i,
    input wire logic signed [FIELD_W-1:0] level_i,
    input wire logic [IDX_W:0] points_i,
    input wire logic [COUNT_W-1:0] length_i,
    input wire logic signed [COUNT_W-1:0] begin_i,
    input wire logic coax_out_en_i,
    input wire logic coax_invert_i,
    input wire logic coax_trig_i,
    input wire logic jack_trig_i,
    input wire logic sample_i,
    input wire logic signed [FIELD_W-1:0] field_x_i,
    input wire logic signed [FIELD_W-1:0] field_y_i,
    input wire logic signed [FIELD_W-1:0] field_z_i,
    input wire logic wait_done_i,
    input wire logic wait_armed_i,
    input wire logic [TO_W-1:0] wait_secs_i,
    input wire logic [IDX_W-1:0] offset_idx_i,
    output logic [4:0] state_o,
    output logic armed_o,
    output logic done_o,
    output logic [COUNT_W-1:0] trig_count_o,
    output logic [IDX_W:0] point_progress_count_o,
    output logic [COUNT_W+IDX_W:0] sample_progress_o,
    output logic [OFFSET_W-1:0] point_offset_list_o,
    output logic offset_valid_o,
    output logic [IDX_W:0] offset_entries_o,
    output logic capture_o,
    output logic signed [COUNT_W-1:0] capture_begin_o,
    output logic coax_trig_o,
    output logic coax_trig_oe_o,
    output logic wait_busy_o,
    output logic wait_end_o
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        atc_state_type st;
        logic coax_prev;
        logic jack_prev;
        logic above_prev;
        logic [COUNT_W-1:0] trig_cnt;
        logic [IDX_W:0] pt_cnt;
        logic [COUNT_W+IDX_W:0] smp_prog;
        logic [COUNT_W-1:0] len_left;
        logic [OFFSET_W-1:0] smp_clk;
        logic [POINTS_MAX-1:0][OFFSET_W-1:0] offs;
        logic [OFFSET_W-1:0] rd_off;
        logic out_lvl;
        logic wait_act;
        logic wait_kind;
        logic [TO_W-1:0] secs_left;
        logic [TO_W-1:0] tick;
        logic wait_fin;
    } atc_regs_type;

    atc_regs_type r_q;
    atc_regs_type r_d;

    logic signed [FIELD_W-1:0] axis_val;
    logic above_now;
    logic ext_in;
    logic ext_prev;
    logic edge_hit;
    logic cross_hit;
    logic src_hit;
    logic trig_evt;
    logic last_pt;

    // ----------------------------------------------------------------
    // source selection and edge detection
    // ----------------------------------------------------------------
    always_comb begin
        unique case (source_i)
            SRC_Y: axis_val = field_y_i;
            SRC_Z: axis_val = field_z_i;
            default: axis_val = field_x_i;
        endcase
    end

    assign above_now = (axis_val > level_i);
    // coax input is blind while the connector drives out
    assign ext_in = (source_i == SRC_COAX) ?
        (coax_trig_i & ~coax_out_en_i) : jack_trig_i;
    assign ext_prev = (source_i == SRC_COAX) ? r_q.coax_prev : r_q.jack_prev;
    assign edge_hit = falling_i ? (ext_prev & ~ext_in)
                                : (~ext_prev & ext_in);
    // crossing judged only on fresh samples
    assign cross_hit = sample_i & (falling_i ?
        (r_q.above_prev & ~above_now) :
        (~r_q.above_prev & above_now));
    always_comb begin
        unique case (source_i)
            SRC_COAX, SRC_JACK: src_hit = edge_hit;
            SRC_X, SRC_Y, SRC_Z: src_hit = cross_hit;
            default: src_hit = 1'b0;
        endcase
    end

    assign trig_evt = (r_q.st == ST_ARMED) & (src_hit | cmd_force_i);
    assign last_pt = (r_q.pt_cnt + 1'b1) >= points_i;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.coax_prev = coax_trig_i & ~coax_out_en_i;
        r_d.jack_prev = jack_trig_i;
        if (sample_i) begin
            r_d.above_prev = above_now;
            r_d.smp_clk = r_q.smp_clk + 64'h1;
        end
        if (src_hit | cmd_force_i) begin
            r_d.trig_cnt = r_q.trig_cnt + 16'h1;
        end
        unique case (r_q.st)
            ST_IDLE: begin
            end
            ST_ARM: begin
                r_d.st = ST_ARMED;
            end
            ST_ARMED: begin
                if (trig_evt) begin
                    r_d.st = ST_TRIGGERED;
                    r_d.len_left = length_i;
                    if (r_q.pt_cnt == '0) begin
                        r_d.smp_clk = 64'h0;
                    end else begin
                        r_d.offs[r_q.pt_cnt[IDX_W-1:0] - 1'b1] =
                            r_q.smp_clk;
                    end
                end
            end
            ST_TRIGGERED: begin
                if (sample_i && r_q.len_left != '0) begin
                    r_d.len_left = r_q.len_left - 16'h1;
                    r_d.smp_prog = r_q.smp_prog + 1'b1;
                end
                if (r_q.len_left == '0 || (sample_i &&
                        r_q.len_left == 16'h1)) begin
                    r_d.pt_cnt = r_q.pt_cnt + 1'b1;
                    r_d.st = last_pt ? ST_DONE : ST_ARMED;
                end
            end
            ST_DONE: begin
            end
        endcase
        if (cmd_force_i && r_q.st != ST_TRIGGERED) begin
            r_d.st = ST_TRIGGERED;
            r_d.len_left = length_i;
            if (r_q.st != ST_ARMED) begin
                r_d.pt_cnt = '0;
                r_d.smp_prog = '0;
                r_d.smp_clk = 64'h0;
            end
        end
        if (cmd_arm_i) begin
            r_d.st = ST_ARMED;
            r_d.pt_cnt = '0;
            r_d.smp_prog = '0;
            r_d.offs = '0;
        end
        if (cmd_clear_i) begin
            r_d.st = ST_IDLE;
        end
        // one pulse per point rather than a toggle: a toggle would give
        // every other point the wrong edge direction
        r_d.out_lvl = (r_d.st == ST_TRIGGERED);
        // wait timer: one second tick prescaler
        r_d.wait_fin = 1'b0;
        if (wait_done_i | wait_armed_i) begin
            if (wait_secs_i == '0 || (wait_done_i &&
                    (r_q.st == ST_DONE || r_q.st == ST_IDLE)) ||
                    (wait_armed_i && r_q.st == ST_ARMED)) begin
                r_d.wait_fin = 1'b1;
                r_d.wait_act = 1'b0;
            end else begin
                r_d.wait_act = 1'b1;
                r_d.wait_kind = wait_armed_i;
                r_d.secs_left = wait_secs_i;
                r_d.tick = CYCLES_PER_S - 1'b1;
            end
        end else if (r_q.wait_act) begin
            if ((r_q.wait_kind && r_q.st == ST_ARMED) ||
                    (!r_q.wait_kind && (r_q.st == ST_DONE ||
                    r_q.st == ST_IDLE)) ||
                    (r_q.secs_left == '0)) begin
                r_d.wait_act = 1'b0;
                r_d.wait_fin = 1'b1;
            end else if (r_q.tick == '0) begin
                r_d.tick = CYCLES_PER_S - 1'b1;
                r_d.secs_left = r_q.secs_left - 1'b1;
            end else begin
                r_d.tick = r_q.tick - 1'b1;
            end
        end
        r_d.rd_off = r_q.offs[offset_idx_i];
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            r_q.trig_cnt <= COUNT_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign state_o = r_q.st;
    assign armed_o = (r_q.st == ST_ARMED);
    assign done_o = (r_q.st == ST_DONE);
    assign trig_count_o = r_q.trig_cnt;
    assign point_progress_count_o = r_q.pt_cnt;
    assign sample_progress_o = r_q.smp_prog;
    assign offset_valid_o = done_o && (points_i > 1);
    assign offset_entries_o = (points_i == '0) ? '0 : points_i - 1'b1;
    assign point_offset_list_o = r_q.rd_off;
    assign capture_o = (r_q.st == ST_TRIGGERED) & sample_i &
        (r_q.len_left != '0);
    // downstream buffer applies the signed start relative to trigger
    assign capture_begin_o = begin_i;
    assign coax_trig_oe_o = coax_out_en_i;
    assign coax_trig_o = coax_out_en_i &
        (r_q.out_lvl ^ coax_invert_i);
    assign wait_busy_o = r_q.wait_act;
    assign wait_end_o = r_q.wait_fin;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_arm_to_armed: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        cmd_arm_i && !cmd_clear_i |=> armed_o)
        else $error("arm did not reach armed");
    a_clear_to_idle: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        cmd_clear_i |=> r_q.st == ST_IDLE)
        else $error("clear did not reach idle");
    a_force_trig: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        cmd_force_i && !cmd_arm_i && !cmd_clear_i
        |=> r_q.st == ST_TRIGGERED)
        else $error("force did not trigger");
    a_done_count: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(done_o) |-> r_q.pt_cnt >= points_i)
        else $error("done reached with too few points");
    a_soft_quiet: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        armed_o && source_i == SRC_SOFT && !cmd_force_i && !cmd_arm_i
        && !cmd_clear_i |=> armed_o)
        else $error("soft source triggered without force");
    a_offs_valid: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        offset_valid_o |-> done_o && points_i > 1)
        else $error("offset list valid outside done");
    a_wait_instant: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        wait_armed_i && wait_secs_i == '0 |=> wait_end_o)
        else $error("zero timeout wait not immediate");
    a_wait_done: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        wait_done_i && r_q.st == ST_IDLE |=> wait_end_o && !wait_busy_o)
        else $error("done wait in idle not immediate");
    a_coax_blind: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        armed_o && coax_out_en_i && source_i == SRC_COAX && !cmd_force_i
        && !cmd_arm_i && !cmd_clear_i |=> armed_o)
        else $error("coax input used while driving");
    a_arm_clears: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        cmd_arm_i && !cmd_clear_i |=> point_progress_count_o == '0
        && sample_progress_o == '0)
        else $error("arm left counts standing");
    a_done_exact: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(done_o) && points_i != '0
        |-> point_progress_count_o == points_i)
        else $error("done with wrong point count");
    a_count_step: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        cmd_force_i |=> trig_count_o == $past(trig_count_o) + 16'h1)
        else $error("force not counted as event");
    a_state_onehot: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        $onehot(state_o))
        else $error("state code not one-hot");
    a_out_off: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        !coax_out_en_i |-> !coax_trig_o && !coax_trig_oe_o)
        else $error("coax driven while output disabled");
    // idle level equals the invert bit, so each point starts on the
    // selected edge
    a_out_idle: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        coax_out_en_i && state_o != ST_TRIGGERED |-> coax_trig_o == coax_invert_i)
        else $error("trigger output idle level wrong");
    a_out_pulse: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        coax_out_en_i && state_o == ST_TRIGGERED |-> coax_trig_o != coax_invert_i)
        else $error("trigger output pulse level wrong");
endmodule : atc_trigger_ctrl

// >>> tb/atc_host_model.sv
// host command source for the trigger controller bench.
// assumes the bench calls its tasks; all changes land on falling edges.
`timescale 1ns/100ps
module atc_host_model
    import atc_pkg::*;
(
    input wire logic clock_i,
    output logic [4:0] cmd_o,
    output logic [2:0] source_o
);
    // ----------------------------------------------------------------
    // commands: 0 arm, 1 clear, 2 force, 3 wait done, 4 wait armed
    // ----------------------------------------------------------------
    initial cmd_o = 5'h00;
    initial source_o = SRC_SOFT;
    // one-cycle pulse, so a command is never taken twice
    task automatic send(input logic [4:0] op);
        @(negedge clock_i);
        cmd_o = op;
        @(negedge clock_i);
        cmd_o = 5'h00;
    endtask : send
    // codes above the axis range are never sent
    task automatic pick(input logic [2:0] s);
        @(negedge clock_i);
        source_o = (s > SRC_Z) ? SRC_SOFT : s;
    endtask : pick
endmodule : atc_host_model

// >>> tb/tb.sv
// self-checking bench of the trigger controller.
// assumes the host model issues commands and picks the source; the bench drives all the rest.
`timescale 1ns/100ps
module tb;
    import atc_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic clock_i;
    logic nrst_i;
    logic [4:0] cmd;
    logic [2:0] src;
    logic falling, oe, coax, jack, smp, inv;
    logic signed [FIELD_W-1:0] fx, fy, fz, lvl;
    logic signed [COUNT_W-1:0] beg;
    logic [IDX_W:0] pts;
    logic [COUNT_W-1:0] len;
    logic [IDX_W-1:0] idx;
    logic [TO_W-1:0] secs;
    logic [4:0] st;
    logic armed, done, ovalid, cap, ctrig, coe, busy, wend, c;
    logic [COUNT_W-1:0] tcnt, c0;
    logic [IDX_W:0] pprog, oent;
    logic [COUNT_W+IDX_W:0] sprog;
    logic [OFFSET_W-1:0] olist;
    logic signed [COUNT_W-1:0] cbeg;
    int mismatches = 0;
    int checks_done = 0;

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    atc_host_model i_atc_host_model (
        .clock_i(clock_i), .cmd_o(cmd), .source_o(src));

    atc_trigger_ctrl i_atc_trigger_ctrl (
        .clock_i(clock_i), .nrst_i(nrst_i),
        .cmd_arm_i(cmd[0]), .cmd_clear_i(cmd[1]), .cmd_force_i(cmd[2]),
        .source_i(src), .falling_i(falling), .level_i(lvl),
        .points_i(pts), .length_i(len), .begin_i(beg),
        .coax_out_en_i(oe), .coax_invert_i(inv), .coax_trig_i(coax),
        .jack_trig_i(jack), .sample_i(smp), .field_x_i(fx),
        .field_y_i(fy), .field_z_i(fz),
        .wait_done_i(cmd[3]), .wait_armed_i(cmd[4]), .wait_secs_i(secs),
        .offset_idx_i(idx), .state_o(st), .armed_o(armed), .done_o(done),
        .trig_count_o(tcnt), .point_progress_count_o(pprog),
        .sample_progress_o(sprog), .point_offset_list_o(olist),
        .offset_valid_o(ovalid), .offset_entries_o(oent),
        .capture_o(cap), .capture_begin_o(cbeg), .coax_trig_o(ctrig),
        .coax_trig_oe_o(coe), .wait_busy_o(busy), .wait_end_o(wend));

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask : tick
    // capture is combinational, so it is looked at inside the strobe cycle
    task automatic sample(input logic [15:0] f, output logic got);
        @(negedge clock_i);
        smp = 1'b1;
        fx = f;
        #1 got = cap;
        @(negedge clock_i);
        smp = 1'b0;
    endtask : sample
    task automatic samples(input int n);
        logic g;
        repeat (n) sample(16'h0000, g);
    endtask : samples
    task automatic edge_on(input logic j);
        @(negedge clock_i);
        if (j) jack = 1'b1;
        else coax = 1'b1;
        @(negedge clock_i);
        jack = 1'b0;
        coax = 1'b0;
    endtask : edge_on
    // the end pulse stands one cycle, so a few cycles are polled
    task automatic ended(output logic got);
        got = 1'b0;
        repeat (4) begin
            if (wend === 1'b1) got = 1'b1;
            @(negedge clock_i);
        end
    endtask : ended

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        check(st, ST_IDLE);
        check({armed, done, coe}, 3'h0);
    endtask : t_reset
    task automatic t_force;
        len = 16'h0002;
        i_atc_host_model.send(5'h01);
        check(st, ST_ARMED);
        check(armed, 1'b1);
        c0 = tcnt;
        i_atc_host_model.send(5'h04);
        check(st, ST_TRIGGERED);
        check(tcnt, c0 + 16'h0001);
        sample(16'h0000, c);
        check(c, 1'b1);
        samples(1);
        tick(2);
        check({done, st}, {1'b1, ST_DONE});
        check(pprog, 4'h1);
        check(sprog, 20'h00002);
        check(ovalid, 1'b0);
        check(cbeg, 16'shff9c);
        sample(16'h0000, c);
        check(c, 1'b0);
    endtask : t_force
    task automatic t_jack;
        i_atc_host_model.pick(SRC_JACK);
        pts = 4'h3;
        len = 16'h0001;
        i_atc_host_model.send(5'h01);
        check({pprog, ovalid}, 5'h00);
        edge_on(1'b1);
        check(st, ST_TRIGGERED);
        samples(4);
        edge_on(1'b1);
        samples(5);
        edge_on(1'b1);
        samples(1);
        tick(2);
        check(st, ST_DONE);
        check(pprog, 4'h3);
        check({oent, ovalid}, 5'h05);
        tick(2);
        check(olist, 64'h0000_0000_0000_0004);
        idx = 3'h1;
        tick(2);
        check(olist, 64'h0000_0000_0000_0009);
    endtask : t_jack
    task automatic t_axis;
        i_atc_host_model.pick(SRC_X);
        falling = 1'b1;
        pts = 4'h1;
        i_atc_host_model.send(5'h01);
        sample(16'h00c8, c);
        sample(16'h012c, c);
        check(st, ST_ARMED);
        sample(16'h0032, c);
        check(st, ST_TRIGGERED);
        sample(16'h0032, c);
        tick(2);
        check(st, ST_DONE);
        falling = 1'b0;
    endtask : t_axis
    task automatic t_soft_coax;
        i_atc_host_model.pick(SRC_SOFT);
        i_atc_host_model.send(5'h01);
        edge_on(1'b1);
        edge_on(1'b0);
        sample(16'h01f4, c);
        check(st, ST_ARMED);
        i_atc_host_model.pick(SRC_COAX);
        oe = 1'b1;
        edge_on(1'b0);
        check({st, coe}, {ST_ARMED, 1'b1});
        oe = 1'b0;
        edge_on(1'b0);
        check({st, ctrig}, {ST_TRIGGERED, 1'b0});
        i_atc_host_model.send(5'h02);
        check(st, ST_IDLE);
    endtask : t_soft_coax
    task automatic t_wait;
        secs = 32'h0000_0005;
        i_atc_host_model.send(5'h08);
        ended(c);
        check(c, 1'b1);
        i_atc_host_model.send(5'h01);
        i_atc_host_model.send(5'h10);
        ended(c);
        check(c, 1'b1);
        secs = 32'h0000_0000;
        i_atc_host_model.send(5'h08);
        ended(c);
        check(c, 1'b1);
        secs = 32'h0000_0001;
        i_atc_host_model.send(5'h08);
        check(busy, 1'b1);
        len = 16'h0000;
        i_atc_host_model.send(5'h04);
        ended(c);
        check({c, st}, {1'b1, ST_DONE});
    endtask : t_wait
    // y then z rising crossings while x stays high; coax drives out
    task automatic t_yz_out;
        i_atc_host_model.pick(SRC_Y);
        {oe, inv} = 2'b10;
        lvl = 16'sh0190;
        beg = 16'sh0064;
        fy = 16'sh0000;
        fz = 16'sh0000;
        pts = 4'h2;
        len = 16'h0001;
        i_atc_host_model.send(5'h01);
        c0 = tcnt;
        sample(16'h7000, c);
        check({st, coe, ctrig}, {ST_ARMED, 2'b10});
        fy = 16'sh01f4;
        sample(16'h7000, c);
        check({st, ctrig}, {ST_TRIGGERED, 1'b1});
        check(cbeg, 16'sh0064);
        sample(16'h7000, c);
        check({c, st, ctrig}, {1'b1, ST_ARMED, 1'b0});
        i_atc_host_model.pick(SRC_Z);
        inv = 1'b1;
        sample(16'h7000, c);
        check({st, ctrig}, {ST_ARMED, 1'b1});
        fz = 16'sh01f4;
        sample(16'h7000, c);
        check({st, ctrig}, {ST_TRIGGERED, 1'b0});
        sample(16'h7000, c);
        tick(2);
        check({done, oent, ovalid}, {1'b1, 4'h1, 1'b1});
        check(tcnt, c0 + 16'h0002);
        idx = 3'h0;
        tick(2);
        check(olist, 64'h0000_0000_0000_0002);
        {oe, inv} = 2'b00;
    endtask : t_yz_out

    initial begin
        #(25 * 20000);
        mismatches++;
        report_and_stop();
    end
    initial begin
        nrst_i = 1'b0;
        {falling, oe, coax, jack, smp, inv} = 6'h00;
        fx = 16'sh0000;
        fy = 16'sh0000;
        fz = 16'sh0000;
        lvl = 16'sh0064;
        beg = 16'shff9c;
        pts = 4'h1;
        len = 16'h0001;
        idx = 3'h0;
        secs = 32'h0000_0000;
        tick(12);
        nrst_i = 1'b1;
        t_reset();
        t_force();
        t_jack();
        t_axis();
        t_soft_coax();
        t_wait();
        t_yz_out();
        report_and_stop();
    end
endmodule : tb
